// >>> inc/dles_pkg.sv
package dles_pkg;

	// Register window of the initiator, byte offsets on the plain port
	localparam int          ADDR_W          = 3;
	localparam int          DATA_W          = 8;
	localparam int          LANES           = 8;
	localparam int          NARROW_LANES    = 4;
	localparam logic [2:0]  OFS_CTRL1       = 3'h1;
	localparam logic [2:0]  OFS_ERR_STAT    = 3'h2;
	localparam logic [2:0]  OFS_PIN_STAT    = 3'h3;

	// Control register 1 fields
	localparam int          CTL_IE_BIT      = 7;
	localparam int          CTL_LIM_LSB     = 0;
	localparam int          LIM_W           = 4;
	localparam logic [3:0]  LIM_RESET       = 4'h0;
	localparam logic        IE_RESET        = 1'b0;

	// Error status register fields
	localparam int          ST_SUMMARY_BIT  = 7;
	localparam int          ST_ACKF_BIT     = 6;
	localparam int          ST_CNCL_BIT     = 5;
	localparam int          ST_TIME_BIT     = 4;
	localparam int          ST_TERR_BIT     = 3;
	localparam int          ST_PARITY_FAULT_FLAG_BIT     = 2;
	localparam int          ST_PHI_BIT      = 1;
	localparam int          ST_PLO_BIT      = 0;
	localparam int          SUB_FLAGS       = 5;
	localparam logic [4:0]  SUB_RESET       = 5'h00;
	localparam logic [1:0]  PAR_RESET       = 2'h0;

	// Pin and busy status register fields
	localparam int          PS_IRQ_BIT      = 7;
	localparam int          PS_BUSY_BIT     = 6;

	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [7:0]  IDLE_COMMAND    = 8'h00;
	localparam logic [7:0]  ALL_LANES_HIGH  = 8'hFF;
	localparam logic [7:0]  NARROW_MASK     = 8'h0F;

	typedef enum logic [1:0] {
		DLES_IDLE,
		DLES_XFER,
		DLES_ACK_WAIT
	} dles_state_e;

endpackage : dles_pkg

// >>> rtl/dles_wait_timer.sv
`timescale 1ns/1ps
module dles_wait_timer
	import dles_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             arm,
	input  wire logic             link_tick,
	input  wire logic             ack_seen,
	input  wire logic [LIM_W-1:0] limit,
	output logic                  expired
);

	logic             running_ff;
	logic             nxt_running;
	logic [LIM_W-1:0] count_ff;
	logic [LIM_W-1:0] nxt_count;
	logic             expired_ff;
	logic             nxt_expired;

	// Each link clock edge without an acknowledge uses one wait state;
	// an acknowledge on the same edge as the last allowed one still wins.
	always_comb begin
		nxt_running = running_ff;
		nxt_count   = count_ff;
		nxt_expired = 1'b0;
		if (arm) begin
			nxt_running = 1'b1;
			nxt_count   = '0;
		end else if (running_ff) begin
			if (ack_seen) begin
				nxt_running = 1'b0;
			end else if (link_tick) begin
				if (count_ff == limit) begin // [R03] [R04]
					nxt_running = 1'b0;
					nxt_expired = 1'b1; // [R02]
				end else begin
					nxt_count = count_ff + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			running_ff <= 1'b0;
			count_ff   <= '0;
			expired_ff <= 1'b0;
		end else begin
			running_ff <= nxt_running;
			count_ff   <= nxt_count;
			expired_ff <= nxt_expired;
		end
	end

	assign expired = expired_ff;

endmodule : dles_wait_timer

// >>> rtl/dles_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// [R01] Interrupt enable bit gates the target's interrupt pin onto the link irq.
// [R02] Four-bit wait limit counts link clocks after last cycle; timeout sets flag.
// [R03] Limit zero: acknowledge due at once, target inserts no wait cycle.
// [R04] Nonzero limit: up to that many wait states before timeout is declared.
// [R05] Wait limit locked once interface is on, unless in special mode.
// [R06] Software writes zero to reserved control bits six to four.
// [R07] Summary flag sets whenever any of the five error flags is raised.
// [R08] Summary flag drives unmasked interrupt; write one clears, zero keeps.
// [R09] Acknowledge fault flag sets when an used data line samples low at ack.
// [R10] Pending summary flag cancels new transactions, sends idle, sets flag.
// [R11] Timeout flag sets when acknowledge wait limit is exceeded.
// [R12] Target error flag sets when target signals error in acknowledge cycle.
// [R13] Parity fault flag sets on parity error in received data.
// [R14] Two low status bits hold received parity bits, upper in bit one.
// [R15] Sub-flags are read-only and clear together with the summary flag.
// [R16] Second status register shows interrupt pin level and busy state.
// [R17] Interrupt pin flag follows pin; only target acknowledge clears it.
// [R18] Busy reads one during a transaction, zero when idle.
// [R19] When enabled, data lines driven low with idle and link clock driven.
// [R20] Sub-flags set in the same cycle as the summary flag.
module dles_top
	import dles_pkg::*;
(
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [DATA_W-1:0] REG_RDATA,
	input  wire logic              INTERFACE_ON,
	input  wire logic              SPECIAL_MODE,
	input  wire logic              WIDE_MODE,
	input  wire logic              LINK_CLK_DIV,
	input  wire logic              LINK_TICK,
	input  wire logic              XFER_REQ,
	input  wire logic              XFER_LAST,
	input  wire logic [LANES-1:0]  TX_DATA,
	input  wire logic              TX_VALID,
	input  wire logic              ACK_CYCLE,
	input  wire logic [LANES-1:0]  ACK_DATA,
	input  wire logic              ACK_TARGET_ERR,
	input  wire logic              RX_PARITY_VALID,
	input  wire logic [1:0]        RX_PARITY,
	input  wire logic              RX_PARITY_ERR,
	input  wire logic              EXT_IRQ_PIN,
	output logic                   XFER_CANCEL,
	output logic                   XFER_ACCEPT,
	output logic                   XFER_TIMEOUT,
	output logic                   TRANSFER_ACTIVE,
	output logic [LANES-1:0]       LINK_DATA_OUT,
	output logic [LANES-1:0]       LINK_DATA_OE,
	output logic                   LINK_CLOCK_OUT,
	output logic                   LINK_IRQ,
	output logic                   ERROR_IRQ
);

	// Register bus decode
	logic wr_ctrl;
	logic wr_err;
	logic rd_hit;

	assign wr_ctrl = REG_WR && (REG_ADDR == OFS_CTRL1);
	assign wr_err  = REG_WR && (REG_ADDR == OFS_ERR_STAT);

	// Control register 1: interrupt enable and acknowledge wait limit
	logic             link_irq_enable_ff;
	logic             nxt_link_irq_enable;
	logic [LIM_W-1:0] ack_wait_limit_ff;
	logic [LIM_W-1:0] nxt_ack_wait_limit;
	logic             limit_locked;

	// Lock follows the enable level, so a write in the very cycle that
	// turns the interface on is still refused.
	assign limit_locked = INTERFACE_ON && !SPECIAL_MODE; // [R05]

	always_comb begin
		nxt_link_irq_enable = link_irq_enable_ff;
		nxt_ack_wait_limit  = ack_wait_limit_ff;
		if (wr_ctrl) begin
			nxt_link_irq_enable = REG_WDATA[CTL_IE_BIT];
			if (!limit_locked) begin // [R05]
				nxt_ack_wait_limit = REG_WDATA[CTL_LIM_LSB +: LIM_W];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			link_irq_enable_ff <= IE_RESET;
			ack_wait_limit_ff  <= LIM_RESET;
		end else begin
			link_irq_enable_ff <= nxt_link_irq_enable;
			ack_wait_limit_ff  <= nxt_ack_wait_limit;
		end
	end

	// Transaction tracking
	dles_state_e state_ff;
	dles_state_e nxt_state;
	logic        cancel_now;
	logic        accept_now;
	logic        timeout_evt;
	logic        error_summary_flag_ff;

	// A request only starts while the interface runs and no error pends.
	assign cancel_now = XFER_REQ && INTERFACE_ON &&
		(state_ff == DLES_IDLE) && error_summary_flag_ff; // [R10]
	assign accept_now = XFER_REQ && INTERFACE_ON &&
		(state_ff == DLES_IDLE) && !error_summary_flag_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			DLES_IDLE: begin
				if (accept_now) begin
					nxt_state = DLES_XFER;
				end
			end
			DLES_XFER: begin
				if (XFER_LAST) begin
					nxt_state = DLES_ACK_WAIT;
				end
			end
			DLES_ACK_WAIT: begin
				if (ACK_CYCLE || timeout_evt) begin
					nxt_state = DLES_IDLE;
				end
			end
			default: begin
				nxt_state = DLES_IDLE;
			end
		endcase
		if (!INTERFACE_ON) begin
			nxt_state = DLES_IDLE;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state_ff <= DLES_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Dropping the interface also stops the timer, otherwise a wait cut
	// short by the forced idle would still expire later with no transfer.
	dles_wait_timer u_wait_timer (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.arm       (XFER_LAST && (state_ff == DLES_XFER)),
		.link_tick (LINK_TICK),
		.ack_seen  (ACK_CYCLE || !INTERFACE_ON),
		.limit     (ack_wait_limit_ff),
		.expired   (timeout_evt)
	);

	// Acknowledge line check: every used lane must read high
	logic [LANES-1:0] lane_used;
	logic [LANES-1:0] lane_ok;

	assign lane_used = WIDE_MODE ? ALL_LANES_HIGH : NARROW_MASK;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_ok[g] = ACK_DATA[g] || !lane_used[g]; // [R09]
		end
	endgenerate

	// Error status: sub-flags and their summary
	logic [SUB_FLAGS-1:0] sub_flags_ff;
	logic [SUB_FLAGS-1:0] nxt_sub_flags;
	logic [SUB_FLAGS-1:0] sub_set;
	logic                 nxt_error_summary;
	logic                 summary_clear;
	logic [1:0]           rx_parity_ff;
	logic [1:0]           nxt_rx_parity;
	logic                 ack_in_wait;

	assign ack_in_wait   = ACK_CYCLE && (state_ff == DLES_ACK_WAIT);
	assign summary_clear = wr_err && REG_WDATA[ST_SUMMARY_BIT]; // [R08]

	// Sub-flag order matches status bits 6 down to 2
	assign sub_set = {
		ack_in_wait && !(&lane_ok),      // [R09]
		cancel_now,                      // [R10]
		timeout_evt,                     // [R11]
		ack_in_wait && ACK_TARGET_ERR,   // [R12]
		RX_PARITY_VALID && RX_PARITY_ERR // [R13]
	};

	// A new error on the clearing cycle survives the clear.
	always_comb begin
		nxt_sub_flags     = sub_set |
			(sub_flags_ff & {SUB_FLAGS{!summary_clear}}); // [R15]
		nxt_error_summary = (|sub_set) ||
			(error_summary_flag_ff && !summary_clear); // [R07] [R08] [R20]
		nxt_rx_parity     = rx_parity_ff;
		if (RX_PARITY_VALID) begin
			nxt_rx_parity = RX_PARITY; // [R14]
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			sub_flags_ff          <= SUB_RESET;
			error_summary_flag_ff <= 1'b0;
			rx_parity_ff          <= PAR_RESET;
		end else begin
			sub_flags_ff          <= nxt_sub_flags;
			error_summary_flag_ff <= nxt_error_summary;
			rx_parity_ff          <= nxt_rx_parity;
		end
	end

	// Link pins: idle command whenever no payload is being sent
	logic [LANES-1:0] link_data_ff;
	logic [LANES-1:0] nxt_link_data;
	logic [LANES-1:0] link_oe_ff;
	logic [LANES-1:0] nxt_link_oe;
	logic             link_clock_ff;
	logic             nxt_link_clock;

	always_comb begin
		nxt_link_data  = IDLE_COMMAND; // [R19]
		nxt_link_oe    = BYTE_ZERO;
		nxt_link_clock = 1'b0;
		if (INTERFACE_ON) begin
			nxt_link_oe    = lane_used; // [R19]
			nxt_link_clock = LINK_CLK_DIV; // [R19]
			if (TX_VALID && (state_ff == DLES_XFER)) begin
				nxt_link_data = TX_DATA & lane_used;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			link_data_ff  <= IDLE_COMMAND;
			link_oe_ff    <= BYTE_ZERO;
			link_clock_ff <= 1'b0;
		end else begin
			link_data_ff  <= nxt_link_data;
			link_oe_ff    <= nxt_link_oe;
			link_clock_ff <= nxt_link_clock;
		end
	end

	// Read path, data valid the cycle after the strobe only
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic [DATA_W-1:0] rd_value;

	assign rd_hit = REG_RD;

	always_comb begin
		rd_value = BYTE_ZERO;
		case (REG_ADDR)
			OFS_CTRL1: begin
				rd_value[CTL_IE_BIT] = link_irq_enable_ff;
				rd_value[CTL_LIM_LSB +: LIM_W] = ack_wait_limit_ff;
			end
			OFS_ERR_STAT: begin
				rd_value[ST_SUMMARY_BIT] = error_summary_flag_ff;
				rd_value[ST_ACKF_BIT:ST_PARITY_FAULT_FLAG_BIT] = sub_flags_ff;
				rd_value[ST_PHI_BIT] = rx_parity_ff[1]; // [R14]
				rd_value[ST_PLO_BIT] = rx_parity_ff[0]; // [R14]
			end
			OFS_PIN_STAT: begin
				rd_value[PS_IRQ_BIT]  = EXT_IRQ_PIN; // [R16] [R17]
				rd_value[PS_BUSY_BIT] = (state_ff != DLES_IDLE); // [R18]
			end
			default: begin
				rd_value = BYTE_ZERO;
			end
		endcase
		nxt_rdata = rd_hit ? rd_value : BYTE_ZERO;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			rdata_ff <= BYTE_ZERO;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Outputs
	assign REG_RDATA       = rdata_ff;
	assign XFER_CANCEL     = cancel_now;
	assign XFER_ACCEPT     = accept_now;
	assign XFER_TIMEOUT    = timeout_evt;
	assign TRANSFER_ACTIVE = (state_ff != DLES_IDLE); // [R18]
	assign LINK_DATA_OUT   = link_data_ff;
	assign LINK_DATA_OE    = link_oe_ff;
	assign LINK_CLOCK_OUT  = link_clock_ff;
	assign LINK_IRQ        = EXT_IRQ_PIN && link_irq_enable_ff; // [R01]
	assign ERROR_IRQ       = error_summary_flag_ff; // [R08]

endmodule : dles_top

// >>> bench/dles_checker_properties.sv
`timescale 1ns/1ps
module dles_checker
	import dles_pkg::*;
(
	input wire logic              CORE_CLK,
	input wire logic              RST_N,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic              REG_WR,
	input wire logic              REG_RD,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic              INTERFACE_ON,
	input wire logic              XFER_REQ,
	input wire logic              RX_PARITY_VALID,
	input wire logic              EXT_IRQ_PIN,
	input wire logic              XFER_CANCEL,
	input wire logic              XFER_ACCEPT,
	input wire logic              XFER_TIMEOUT,
	input wire logic              TRANSFER_ACTIVE,
	input wire logic [LANES-1:0]  LINK_DATA_OUT,
	input wire logic [LANES-1:0]  LINK_DATA_OE,
	input wire logic              LINK_IRQ,
	input wire logic              ERROR_IRQ
);
	logic ie_ff;
	logic nxt_ie;
	logic wst;
	logic quiet;
	assign wst = REG_WR && REG_ADDR == OFS_ERR_STAT;
	// Nothing in flight that could raise a flag next cycle
	assign quiet = !TRANSFER_ACTIVE && !XFER_REQ && !RX_PARITY_VALID;
	always_comb begin
		nxt_ie = ie_ff;
		if (REG_WR && REG_ADDR == OFS_CTRL1) begin
			nxt_ie = REG_WDATA[CTL_IE_BIT];
		end
	end
	always_ff @(posedge CORE_CLK) begin
		ie_ff <= RST_N ? nxt_ie : IE_RESET;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	AST_IRQ_GATE: assert property (LINK_IRQ == (EXT_IRQ_PIN && ie_ff))
		else $error("link irq not gated by enable");
	AST_TMO_FLAG: assert property (XFER_TIMEOUT |=>
		ERROR_IRQ && !TRANSFER_ACTIVE)
		else $error("timeout without flag or busy end");
	AST_CNCL: assert property (XFER_CANCEL |-> ERROR_IRQ && !XFER_ACCEPT)
		else $error("cancel without pending error");
	AST_BUSY: assert property (XFER_ACCEPT |=> TRANSFER_ACTIVE)
		else $error("busy missing after accept");
	AST_W0_KEEP: assert property (wst && !REG_WDATA[ST_SUMMARY_BIT]
		&& ERROR_IRQ |=> ERROR_IRQ)
		else $error("zero write cleared summary");
	AST_W1_CLR: assert property (wst && REG_WDATA[ST_SUMMARY_BIT]
		&& quiet |=> !ERROR_IRQ)
		else $error("one write did not clear summary");
	AST_NO_SPUR: assert property (!ERROR_IRQ && quiet |=> !ERROR_IRQ)
		else $error("summary rose without cause");
	AST_STAT_SUM: assert property (REG_RD
		&& REG_ADDR == OFS_ERR_STAT |=> REG_RDATA[7] == |REG_RDATA[6:2])
		else $error("summary and sub flags disagree");
	AST_PIN_STAT: assert property (REG_RD
		&& REG_ADDR == OFS_PIN_STAT |=> REG_RDATA
		== {$past(EXT_IRQ_PIN), $past(TRANSFER_ACTIVE), 6'h00})
		else $error("pin status read wrong");
	AST_IDLE_LINE: assert property (
		(INTERFACE_ON && !TRANSFER_ACTIVE)[*3]
		|-> LINK_DATA_OUT == IDLE_COMMAND && LINK_DATA_OE != BYTE_ZERO)
		else $error("idle link not driven low");
	CVR_TMO: cover property (XFER_TIMEOUT);
	CVR_CNCL: cover property (XFER_CANCEL);
	CVR_IRQ: cover property (LINK_IRQ);
endmodule : dles_checker
bind dles_top dles_checker dles_checker_inst (.*);

// >>> bench/dles_target_model.sv
`timescale 1ns/1ps
module dles_target_model
	import dles_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             last,
	input  wire logic [3:0]       waits,
	input  wire logic             silent,
	input  wire logic             terr_req,
	input  wire logic [LANES-1:0] lanes,
	input  wire logic             irq_req,
	output logic                  ack,
	output logic      [LANES-1:0] ack_data,
	output logic                  terr,
	output logic                  irq
);
	logic       pend;
	logic [3:0] cnt;
	always_ff @(posedge clk) begin
		irq <= irq_req;
		if (!rst_n || ack) begin
			pend <= 1'h0;
		end else if (last) begin
			pend <= !silent;
			cnt  <= waits;
		end else if (pend && cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	assign ack = pend && cnt == 4'h0;
	// Lines are not held outside the ack cycle
	assign ack_data = ack ? lanes : ~lanes;
	assign terr = ack && terr_req;
endmodule : dles_target_model

// >>> bench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("BAD %s exp %h got %h", n, e, g); \
	end \
end
module testbench
	import dles_pkg::*;
;
	int fails = 0;
	int total_checks = 0;
	logic CORE_CLK = 1'h0, RST_N = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0;
	logic INTERFACE_ON = 1'h0, SPECIAL_MODE = 1'h1, WIDE_MODE = 1'h1;
	logic LINK_CLK_DIV = 1'h0, LINK_TICK = 1'h1, TX_VALID = 1'h0;
	logic XFER_REQ = 1'h0, XFER_LAST = 1'h0, silent = 1'h0;
	logic terr_req = 1'h0, perr = 1'h0, irq_req = 1'h0;
	logic [ADDR_W-1:0] REG_ADDR = 3'h0;
	logic [7:0] REG_WDATA = 8'h00, TX_DATA = 8'h00, lanes = 8'hFF;
	logic [3:0] waits = 4'h0;
	logic [1:0] par = 2'h0;
	logic [7:0] REG_RDATA, LINK_DATA_OUT, LINK_DATA_OE, ACK_DATA;
	logic [1:0] RX_PARITY;
	logic XFER_CANCEL, XFER_ACCEPT, XFER_TIMEOUT, TRANSFER_ACTIVE;
	logic LINK_CLOCK_OUT, LINK_IRQ, ERROR_IRQ, ACK_CYCLE, ACK_TARGET_ERR;
	logic EXT_IRQ_PIN, RX_PARITY_VALID, RX_PARITY_ERR;
	assign RX_PARITY_VALID = ACK_CYCLE;
	assign RX_PARITY = par;
	assign RX_PARITY_ERR = ACK_CYCLE && perr;
	always #2 CORE_CLK = ~CORE_CLK;
	// Link clock source at half the bus rate, running free as when enabled
	always @(posedge CORE_CLK) LINK_CLK_DIV <= ~LINK_CLK_DIV;
	dles_top dles_top_inst (.*);
	dles_target_model dles_target_model_inst (.clk(CORE_CLK), .rst_n(RST_N),
		.last(XFER_LAST), .waits(waits), .silent(silent),
		.terr_req(terr_req), .lanes(lanes), .irq_req(irq_req),
		.ack(ACK_CYCLE), .ack_data(ACK_DATA), .terr(ACK_TARGET_ERR),
		.irq(EXT_IRQ_PIN));
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'h1;
		@(posedge CORE_CLK);
		REG_WR    <= 1'h0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'h1;
		@(posedge CORE_CLK);
		REG_RD   <= 1'h0;
		#1 d = REG_RDATA;
	endtask : rd
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic t_regs;
		logic [7:0] v;
		wr(3'h5, 8'hFF);
		for (int a = 1; a < 6; a++) begin
			rd(a[2:0], v);
			`CHK("reset value", 8'h00, v)
		end
		$display("end t_regs");
	endtask : t_regs
	task automatic t_irq;
		logic [7:0] v;
		wr(OFS_CTRL1, 8'h85);
		rd(OFS_CTRL1, v);
		`CHK("ctrl", 8'h85, v)
		irq_req <= 1'h1;
		repeat (2) @(posedge CORE_CLK);
		#1 `CHK("irq on", 1'h1, LINK_IRQ)
		rd(OFS_PIN_STAT, v);
		`CHK("pin stat", 8'h80, v)
		wr(OFS_CTRL1, 8'h05);
		#1 `CHK("irq off", 1'h0, LINK_IRQ)
		irq_req <= 1'h0;
		$display("end t_irq");
	endtask : t_irq
	task automatic run(input logic [3:0] lim, w, input logic sil, te, pe,
		input logic [7:0] ln, ex);
		logic [7:0] v;
		int n;
		wr(OFS_CTRL1, {4'h0, lim});
		waits    <= w;
		silent   <= sil;
		terr_req <= te;
		perr     <= pe;
		lanes    <= ln;
		par      <= ex[1:0];
		XFER_REQ <= 1'h1;
		#1 `CHK("accept", 1'h1, XFER_ACCEPT)
		@(posedge CORE_CLK);
		XFER_REQ  <= 1'h0;
		XFER_LAST <= 1'h1;
		@(posedge CORE_CLK);
		XFER_LAST <= 1'h0;
		#1 `CHK("busy", 1'h1, TRANSFER_ACTIVE)
		n = 0;
		while (TRANSFER_ACTIVE !== 1'h0 && n < 50) begin
			@(posedge CORE_CLK);
			#1 n++;
		end
		`CHK("idle", 1'h0, TRANSFER_ACTIVE)
		rd(OFS_ERR_STAT, v);
		`CHK("status", ex, v)
		if (ex[7]) begin
			@(posedge CORE_CLK);
			XFER_REQ <= 1'h1;
			#1 `CHK("cancel", 1'h1, XFER_CANCEL)
			@(posedge CORE_CLK);
			XFER_REQ <= 1'h0;
			wr(OFS_ERR_STAT, 8'h00);
			rd(OFS_ERR_STAT, v);
			`CHK("cancelled", ex | 8'hA0, v)
		end
		wr(OFS_ERR_STAT, 8'h80);
		rd(OFS_ERR_STAT, v);
		`CHK("cleared", {6'h00, ex[1:0]}, v)
	endtask : run
	task automatic t_xfer;
		// limit, waits, silent, target error, parity error, lanes, status
		logic [35:0] tc [7] = '{36'h00000_FF_02, 36'h01000_FF_92,
			36'h33000_FF_01, 36'h30100_FF_91, 36'h00010_FF_8A,
			36'h00000_FE_C2, 36'h00001_FF_87};
		for (int i = 0; i < 7; i++) begin
			run(tc[i][35:32], tc[i][31:28], tc[i][24], tc[i][20],
				tc[i][16], tc[i][15:8], tc[i][7:0]);
		end
		$display("end t_xfer");
	endtask : t_xfer
	task automatic t_link;
		logic [7:0] v;
		WIDE_MODE <= 1'h0;
		// Narrow mode: upper lanes low at the ack are not a line fault
		run(4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 8'h0F, 8'h02);
		@(posedge CORE_CLK);
		#1 `CHK("narrow oe", 8'h0F, LINK_DATA_OE)
		`CHK("idle data", IDLE_COMMAND, LINK_DATA_OUT)
		`CHK("link clock", ~LINK_CLK_DIV, LINK_CLOCK_OUT)
		@(posedge CORE_CLK);
		TX_DATA  <= 8'hA5;
		TX_VALID <= 1'h1;
		XFER_REQ <= 1'h1;
		@(posedge CORE_CLK);
		XFER_REQ <= 1'h0;
		@(posedge CORE_CLK);
		TX_VALID  <= 1'h0;
		XFER_LAST <= 1'h1;
		#1 `CHK("payload", 8'h05, LINK_DATA_OUT)
		@(posedge CORE_CLK);
		XFER_LAST <= 1'h0;
		repeat (2) @(posedge CORE_CLK);
		rd(OFS_ERR_STAT, v);
		`CHK("narrow ack", 8'h02, v)
		$display("end t_link");
	endtask : t_link
	task automatic t_lock;
		logic [7:0] v;
		SPECIAL_MODE <= 1'h0;
		wr(OFS_CTRL1, 8'h8A);
		rd(OFS_CTRL1, v);
		`CHK("locked", 8'h80, v)
		SPECIAL_MODE <= 1'h1;
		wr(OFS_CTRL1, 8'h0A);
		rd(OFS_CTRL1, v);
		`CHK("special", 8'h0A, v)
		$display("end t_lock");
	endtask : t_lock
	initial begin
		repeat (16) @(posedge CORE_CLK);
		RST_N <= 1'h1;
		t_regs;
		t_irq;
		INTERFACE_ON <= 1'h1;
		t_xfer;
		t_link;
		t_lock;
		test_done;
	end
	initial begin
		#20000;
		fails++;
		test_done;
	end
endmodule : testbench
